// [hbgc_pkg.sv]
// Package for the H-bridge gate command block: timing, register map, types.
// Assumes a 10 MHz core clock; all cycle counts are derived from it here.
package hbgc_pkg;

    // Clock
    localparam int CLK_PERIOD_NS   = 100;

    // Timing figures in their own units, then in cycles
    localparam int PWM_FREQ_HZ     = 25000;
    localparam int PWM_PERIOD_CYC  = 1000000000 / (PWM_FREQ_HZ * CLK_PERIOD_NS);
    localparam int DEAD_TIME_NS    = 2500;
    localparam int DEAD_CYC        = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BRAKE_DELAY_US  = 200;
    localparam int BRAKE_CYC       = (BRAKE_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WD_TIMEOUT_MS   = 1;
    localparam int WD_TIMEOUT_CYC  = (WD_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
    localparam int RST_PULSE_US    = 20;
    localparam int RST_PULSE_CYC   = (RST_PULSE_US * 1000) / CLK_PERIOD_NS;

    localparam int PWM_CNT_W       = $clog2(PWM_PERIOD_CYC);
    localparam int DEAD_W          = $clog2(DEAD_CYC + 1);
    localparam int BRAKE_W         = $clog2(BRAKE_CYC + 2);
    localparam int RST_W           = $clog2(RST_PULSE_CYC + 1);

    // Analog speed code thresholds (8-bit code, full scale 5 V)
    localparam logic [7:0] ANA_LOW_CODE  = 8'h3D;
    localparam logic [7:0] ANA_HIGH_CODE = 8'hB8;
    localparam logic [7:0] ANA_SPAN      = 8'h7B;

    // Register map (byte addresses)
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
    localparam logic [11:0] ADDR_SPEED    = 12'h010;

    localparam int          CTRL_WD_EN_BIT = 0;
    localparam logic [0:0]  CTRL_RST       = 1'h1;
    localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;

    // Synchronised pins, bit order fixed by field order
    typedef struct packed {
        logic standbyN;
        logic speedCommand;
        logic directionSelect;
        logic pwmFreqSetPin;
        logic overvoltageLockout;
        logic undervoltageLockout;
        logic supervisorResetN;
        logic watchdogKick;
    } hbgc_pins_t;

    localparam hbgc_pins_t PINS_RST = 8'h00;

    // Interrupt events, bit 0 is the watchdog timeout
    typedef struct packed {
        logic brakeEntry;
        logic overvoltage;
        logic undervoltage;
        logic wdTimeout;
    } hbgc_evt_t;

    // Requested leg state
    typedef enum logic [1:0] {
        LEG_OFF  = 2'b00,
        LEG_LOW  = 2'b01,
        LEG_HIGH = 2'b10
    } hbgc_leg_cmd_t;

    // Applied gate state: bit 0 low switch, bit 1 high switch
    typedef enum logic [1:0] {
        GS_OFF  = 2'b00,
        GS_LOW  = 2'b01,
        GS_HIGH = 2'b10
    } hbgc_gate_state_t;

endpackage

// [hbgc_leg.sv]
// One half-bridge leg: applies the requested switch with a dead gap.
// Assumes a synchronous reset copy and a request from the same clock.
`timescale 1ns/1ps
module hbgc_leg
    import hbgc_pkg::*;
(
    input  wire logic          coreClk,
    input  wire logic          rstN,
    input  hbgc_leg_cmd_t      legCmd,
    output logic               lowSwitch,
    output logic               highSwitch
);

    hbgc_gate_state_t  stateQ;
    logic [DEAD_W-1:0] gapQ;
    logic [DEAD_W:0]   idleCntQ;

    // Off is applied at once; turning on waits out the gap
    always_ff @(posedge coreClk or negedge rstN) begin
        if (!rstN) begin
            stateQ <= GS_OFF;
            gapQ   <= DEAD_W'(DEAD_CYC);
        end else begin
            case (stateQ)
                GS_OFF: begin
                    if (gapQ != '0) begin
                        gapQ <= gapQ - 1'b1;
                    end else if (legCmd == LEG_LOW) begin
                        stateQ <= GS_LOW;
                    end else if (legCmd == LEG_HIGH) begin
                        stateQ <= GS_HIGH;
                    end
                end
                GS_LOW: begin
                    if (legCmd != LEG_LOW) begin
                        stateQ <= GS_OFF;
                        gapQ   <= DEAD_W'(DEAD_CYC);
                    end
                end
                GS_HIGH: begin
                    if (legCmd != LEG_HIGH) begin
                        stateQ <= GS_OFF;
                        gapQ   <= DEAD_W'(DEAD_CYC);
                    end
                end
                default: begin
                    stateQ <= GS_OFF;
                    gapQ   <= DEAD_W'(DEAD_CYC);
                end
            endcase
        end
    end

    assign lowSwitch  = stateQ[0];
    assign highSwitch = stateQ[1];

    // Cycles both switches have been off, saturating
    always_ff @(posedge coreClk or negedge rstN) begin
        if (!rstN) begin
            idleCntQ <= '0;
        end else if (lowSwitch || highSwitch) begin
            idleCntQ <= '0;
        end else if (idleCntQ != '1) begin
            idleCntQ <= idleCntQ + 1'b1;
        end
    end

    no_shoot_through_a: assert property (
        @(posedge coreClk) disable iff (!rstN) !(lowSwitch && highSwitch))
        else $error("leg low and high switch on together");

    dead_gap_a: assert property (
        @(posedge coreClk) disable iff (!rstN)
        ((lowSwitch || highSwitch) && !$past(lowSwitch || highSwitch))
        |-> ($past(idleCntQ) >= (DEAD_W+1)'(DEAD_CYC)))
        else $error("switch turned on before dead gap elapsed");

    off_request_a: assert property (
        @(posedge coreClk) disable iff (!rstN)
        (legCmd == LEG_OFF) |=> (!lowSwitch && !highSwitch))
        else $error("off request not applied next cycle");

endmodule // hbgc_leg

// [hbgc_top.sv]
// Gate command logic for a DC motor H-bridge of four transistors, with APB registers.
// Assumes asynchronous pins, an 8-bit speed level code from an ADC on core_clk.
//
// What this block does
// - Standby input low forces all four gate commands off.
// - Under-voltage, over-voltage, supervisor reset or watchdog timeout disables all gates.
// - Zero speed brakes: direction low both low sides, high both high sides.
// - Brake only after speed stayed zero for more than 200 us.
// - Modulate one low side while the diagonal high side stays on.
// - Forward modulates leg 2 low; backward mirrors; full command keeps it on.
// - High side of the modulated leg is the complement of its low side.
// - Never both switches of one leg on together.
// - Insert about 2.5 us gap at every commutation within a leg.
// - Frequency pin grounded: speed input is the modulation waveform directly.
// - Analog level: below 1.2 V brake, to 3.6 V proportional, above full.
// - Internal modulation runs at 25 kHz.
// - Watchdog times out after 1 ms without a retrigger pulse.
// - On timeout pulse reset output low about 20 us, gates off.
// - Stay disabled after timeout until kick pulses appear again.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module hbgc_top
    import hbgc_pkg::*;
#(
    parameter int WD_CYC = WD_TIMEOUT_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pins
    input  wire logic              standbyN,
    input  wire logic              speedCommand,
    input  wire logic              directionSelect,
    input  wire logic              pwmFreqSetPin,
    input  wire logic              overvoltageLockout,
    input  wire logic              undervoltageLockout,
    input  wire logic              supervisorResetN,
    input  wire logic              watchdogKick,
    input  wire logic [7:0]        speedLevel,
    output logic                   leg1LowSwitch,
    output logic                   leg1HighSwitch,
    output logic                   leg2LowSwitch,
    output logic                   leg2HighSwitch,
    output logic                   resetOut,
    output logic                   resetOutEnN,
    output logic                   irq
);

    localparam int WD_W = $clog2(WD_CYC + 1);

    logic [1:0]        rstSyncQ;
    logic              rstN;
    hbgc_pins_t        pinRaw;
    hbgc_pins_t        pinS1Q;
    hbgc_pins_t        pinS2Q;
    hbgc_pins_t        pinS3Q;
    hbgc_pins_t        pinQ;
    logic [7:0]        speedLevelQ;
    logic [PWM_CNT_W-1:0] pwmCntQ;
    logic              analogMode;
    logic              zeroLevel;
    logic              modD;
    logic              modQ;
    logic [BRAKE_W-1:0] zeroCntQ;
    logic              brakeQ;
    logic              kickPrevQ;
    logic              kickEdge;
    logic [WD_W-1:0]   wdCntQ;
    logic              wdExpire;
    logic              wdTimeoutQ;
    logic [RST_W-1:0]  rstCntQ;
    logic              disableAll;
    logic              standbyActive;
    hbgc_leg_cmd_t     leg1Cmd;
    hbgc_leg_cmd_t     leg2Cmd;
    logic [0:0]        ctrlQ;
    hbgc_evt_t         irqStatQ;
    hbgc_evt_t         irqMaskQ;
    hbgc_evt_t         evt;
    logic              uvPrevQ;
    logic              ovPrevQ;
    logic              brakePrevQ;
    logic              apbWrite;
    logic              apbSetup;
    logic [31:0]       statusWord;

    function automatic logic addrHit(input logic [ADDR_W-1:0] a);
        addrHit = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_IRQ_STAT)
               || (a == ADDR_IRQ_MASK) || (a == ADDR_SPEED);
    endfunction

    // Proportional duty between the two thresholds
    function automatic logic anaDuty(input logic [7:0] code, input logic [PWM_CNT_W-1:0] cnt);
        logic [16:0] lhs;
        logic [16:0] rhs;
        lhs = 17'(cnt) * 17'(ANA_SPAN);
        rhs = 17'(code - ANA_LOW_CODE) * 17'(PWM_PERIOD_CYC);
        if (code < ANA_LOW_CODE) begin
            anaDuty = 1'b0;
        end else if (code >= ANA_HIGH_CODE) begin
            anaDuty = 1'b1;
        end else begin
            anaDuty = lhs < rhs;
        end
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSyncQ <= 2'h0;
        end else begin
            rstSyncQ <= {rstSyncQ[0], 1'b1};
        end
    end
    assign rstN = rstSyncQ[1];

    // Pin synchroniser: three stages, accepted once stages two and three agree
    assign pinRaw = '{standbyN, speedCommand, directionSelect, pwmFreqSetPin,
                      overvoltageLockout, undervoltageLockout, supervisorResetN,
                      watchdogKick};

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            pinS1Q <= PINS_RST;
            pinS2Q <= PINS_RST;
            pinS3Q <= PINS_RST;
            pinQ   <= PINS_RST;
        end else begin
            pinS1Q <= pinRaw;
            pinS2Q <= pinS1Q;
            pinS3Q <= pinS2Q;
            pinQ   <= (pinS2Q & ~(pinS2Q ^ pinS3Q)) | (pinQ & (pinS2Q ^ pinS3Q));
        end
    end

    // Speed level code and internal modulation counter
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            speedLevelQ <= 8'h00;
            pwmCntQ     <= '0;
        end else begin
            speedLevelQ <= speedLevel;
            if (pwmCntQ == PWM_CNT_W'(PWM_PERIOD_CYC - 1)) begin
                pwmCntQ <= '0;
            end else begin
                pwmCntQ <= pwmCntQ + 1'b1;
            end
        end
    end

    assign analogMode = pinQ.pwmFreqSetPin;
    assign zeroLevel  = analogMode ? (speedLevelQ < ANA_LOW_CODE)
                                   : !pinQ.speedCommand;
    assign modD       = analogMode ? anaDuty(speedLevelQ, pwmCntQ)
                                   : pinQ.speedCommand;

    // Modulation and brake detection
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            modQ     <= 1'b0;
            zeroCntQ <= '0;
            brakeQ   <= 1'b0;
        end else begin
            modQ <= modD;
            if (!zeroLevel) begin
                zeroCntQ <= '0;
            end else if (zeroCntQ != BRAKE_W'(BRAKE_CYC + 1)) begin
                zeroCntQ <= zeroCntQ + 1'b1;
            end
            brakeQ <= zeroLevel && (zeroCntQ >= BRAKE_W'(BRAKE_CYC));
        end
    end

    // Watchdog
    assign kickEdge = pinQ.watchdogKick && !kickPrevQ;
    assign wdExpire = ctrlQ[CTRL_WD_EN_BIT] && !wdTimeoutQ && !kickEdge
                   && (wdCntQ == WD_W'(WD_CYC - 1));

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            kickPrevQ  <= 1'b0;
            wdCntQ     <= '0;
            wdTimeoutQ <= 1'b0;
        end else begin
            kickPrevQ <= pinQ.watchdogKick;
            if (kickEdge || !ctrlQ[CTRL_WD_EN_BIT] || wdExpire) begin
                wdCntQ <= '0;
            end else if (!wdTimeoutQ) begin
                wdCntQ <= wdCntQ + 1'b1;
            end
            if (wdExpire) begin
                wdTimeoutQ <= 1'b1;
            end else if (kickEdge || !ctrlQ[CTRL_WD_EN_BIT]) begin
                wdTimeoutQ <= 1'b0;
            end
        end
    end

    // Reset output pulse, open drain
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            rstCntQ     <= '0;
            resetOutEnN <= 1'b1;
        end else begin
            if (wdExpire) begin
                rstCntQ <= RST_W'(RST_PULSE_CYC);
            end else if (rstCntQ != '0) begin
                rstCntQ <= rstCntQ - 1'b1;
            end
            resetOutEnN <= !(wdExpire || (rstCntQ > RST_W'(1)));
        end
    end
    assign resetOut = 1'b0;

    // Gate requests per leg
    assign standbyActive = !pinQ.standbyN;
    assign disableAll    = pinQ.undervoltageLockout || pinQ.overvoltageLockout
                        || !pinQ.supervisorResetN || wdTimeoutQ || (rstCntQ != '0);

    always_comb begin
        leg1Cmd = LEG_OFF;
        leg2Cmd = LEG_OFF;
        if (standbyActive || disableAll) begin
            leg1Cmd = LEG_OFF;
            leg2Cmd = LEG_OFF;
        end else if (brakeQ) begin
            leg1Cmd = pinQ.directionSelect ? LEG_HIGH : LEG_LOW;
            leg2Cmd = pinQ.directionSelect ? LEG_HIGH : LEG_LOW;
        end else if (!pinQ.directionSelect) begin
            leg1Cmd = LEG_HIGH;
            leg2Cmd = modQ ? LEG_LOW : LEG_HIGH;
        end else begin
            leg1Cmd = modQ ? LEG_LOW : LEG_HIGH;
            leg2Cmd = LEG_HIGH;
        end
    end

    hbgc_leg u_leg1 (
        .coreClk    (core_clk),
        .rstN       (rstN),
        .legCmd     (leg1Cmd),
        .lowSwitch  (leg1LowSwitch),
        .highSwitch (leg1HighSwitch)
    );

    hbgc_leg u_leg2 (
        .coreClk    (core_clk),
        .rstN       (rstN),
        .legCmd     (leg2Cmd),
        .lowSwitch  (leg2LowSwitch),
        .highSwitch (leg2HighSwitch)
    );

    // Events
    assign evt = '{brakeEntry:   brakeQ && !brakePrevQ,
                   overvoltage:  pinQ.overvoltageLockout && !ovPrevQ,
                   undervoltage: pinQ.undervoltageLockout && !uvPrevQ,
                   wdTimeout:    wdExpire};

    // APB slave, zero wait states
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite && addrHit(paddr);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addrHit(paddr);

    assign statusWord = {20'h00000, leg2HighSwitch, leg2LowSwitch, leg1HighSwitch,
                         leg1LowSwitch, 2'h0, pinQ.directionSelect, wdTimeoutQ,
                         analogMode, brakeQ, disableAll, standbyActive};

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            ctrlQ      <= CTRL_RST;
            irqMaskQ   <= IRQ_MASK_RST;
            irqStatQ   <= 4'h0;
            uvPrevQ    <= 1'b0;
            ovPrevQ    <= 1'b0;
            brakePrevQ <= 1'b0;
        end else begin
            uvPrevQ    <= pinQ.undervoltageLockout;
            ovPrevQ    <= pinQ.overvoltageLockout;
            brakePrevQ <= brakeQ;
            if (apbWrite && paddr == ADDR_CTRL) begin
                ctrlQ <= pwdata[0:0];
            end
            if (apbWrite && paddr == ADDR_IRQ_MASK) begin
                irqMaskQ <= pwdata[3:0];
            end
            if (apbWrite && paddr == ADDR_IRQ_STAT) begin
                irqStatQ <= (irqStatQ & ~pwdata[3:0]) | evt;
            end else begin
                irqStatQ <= irqStatQ | evt;
            end
        end
    end

    // Read data latched in the setup phase
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            prdata <= 32'h00000000;
            irq    <= 1'b0;
        end else begin
            irq <= |(irqStatQ & irqMaskQ);
            if (apbSetup && !pwrite) begin
                case (paddr)
                    ADDR_CTRL:     prdata <= {31'h00000000, ctrlQ};
                    ADDR_STATUS:   prdata <= statusWord;
                    ADDR_IRQ_STAT: prdata <= {28'h0000000, irqStatQ};
                    ADDR_IRQ_MASK: prdata <= {28'h0000000, irqMaskQ};
                    ADDR_SPEED:    prdata <= {24'h000000, speedLevelQ};
                    default:       prdata <= 32'h00000000;
                endcase
            end
        end
    end

    standby_off_a: assert property (
        @(posedge core_clk) disable iff (!rstN) standbyActive |=>
        !(leg1LowSwitch || leg1HighSwitch || leg2LowSwitch || leg2HighSwitch))
        else $error("gate on during standby");

    disable_off_a: assert property (
        @(posedge core_clk) disable iff (!rstN) disableAll |=>
        !(leg1LowSwitch || leg1HighSwitch || leg2LowSwitch || leg2HighSwitch))
        else $error("gate on while disabled");

    brake_request_a: assert property (
        @(posedge core_clk) disable iff (!rstN)
        (brakeQ && !standbyActive && !disableAll) |->
        (leg1Cmd == leg2Cmd) && (leg1Cmd == (pinQ.directionSelect ? LEG_HIGH : LEG_LOW)))
        else $error("brake request pattern wrong");

    brake_wait_a: assert property (
        @(posedge core_clk) disable iff (!rstN)
        $rose(brakeQ) |-> $past(zeroLevel) && (zeroCntQ > BRAKE_W'(BRAKE_CYC)))
        else $error("brake entered too early");

    forward_drive_a: assert property (
        @(posedge core_clk) disable iff (!rstN)
        (!brakeQ && !standbyActive && !disableAll && !pinQ.directionSelect) |->
        (leg1Cmd == LEG_HIGH) && (leg2Cmd == (modQ ? LEG_LOW : LEG_HIGH)))
        else $error("forward drive pattern wrong");

    digital_pass_a: assert property (
        @(posedge core_clk) disable iff (!rstN)
        (!analogMode && $past(!analogMode)) |-> (modQ == $past(pinQ.speedCommand)))
        else $error("digital speed not passed through");

    pwm_period_a: assert property (
        @(posedge core_clk) disable iff (!rstN)
        (pwmCntQ == PWM_CNT_W'(PWM_PERIOD_CYC - 1)) |=> (pwmCntQ == '0) ##1 (pwmCntQ == 1))
        else $error("modulation period wrong");

    wd_timeout_a: assert property (
        @(posedge core_clk) disable iff (!rstN)
        (ctrlQ[CTRL_WD_EN_BIT] && !wdTimeoutQ && !kickEdge && wdCntQ == WD_W'(WD_CYC - 1))
        |=> wdTimeoutQ && !resetOutEnN)
        else $error("watchdog timeout missed");

    reset_pulse_a: assert property (
        @(posedge core_clk) disable iff (!rstN)
        $fell(resetOutEnN) |-> (!resetOutEnN)[*8] ##0 (rstCntQ == RST_W'(RST_PULSE_CYC - 7)))
        else $error("reset pulse wrong");

    wd_hold_a: assert property (
        @(posedge core_clk) disable iff (!rstN)
        (wdTimeoutQ && !kickEdge && ctrlQ[CTRL_WD_EN_BIT]) |=> wdTimeoutQ)
        else $error("left timeout without kick");

endmodule // hbgc_top

// [hbgc_mcu_model.sv]
// Controller model: drives the speed and watchdog kick pins.
// Assumes the bench changes its mode inputs just after a rising edge.
`timescale 1ns/1ps
module hbgc_mcu_model (
    input  wire logic clk,
    input  wire logic kickEn,
    input  wire logic speedIn,
    output logic      kick,
    output logic      speedCommand
);
    logic [5:0] cntQ = 6'h00;
    initial kick = 1'h0;
    initial speedCommand = 1'h0;
    // Kick pulse 8 cycles wide every 64 cycles
    always @(posedge clk) begin
        cntQ <= cntQ + 6'h01;
        kick <= kickEn && (cntQ < 6'h08);
    end
    always @(posedge clk) begin
        speedCommand <= speedIn;
    end
endmodule // hbgc_mcu_model

// [hbgc_top_tb.sv]
// Self-checking bench for the H-bridge gate command block.
// Assumes a controller model on the pins and an APB master in tasks.
`timescale 1ns/1ps
module hbgc_top_tb;
    import hbgc_pkg::*;
    logic        core_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, e, standbyN = 1'h0, speedIn = 1'h0, dirSel = 1'h0;
    logic        freqPin = 1'h0, ovl = 1'h0, uvl = 1'h0, supN = 1'h1, kickEn = 1'h1;
    logic        kick, speedCommand, l1L, l1H, l2L, l2H, resetOut, resetOutEnN, irq;
    logic [7:0]  speedLevel = 8'h00;
    wire  [3:0]  legs = {l1L, l1H, l2L, l2H};
    int          failCount = 0, numChecks = 0, n;
    always #50 core_clk = ~core_clk;
    hbgc_mcu_model mcu (.clk(core_clk), .kickEn(kickEn), .speedIn(speedIn), .kick(kick),
        .speedCommand(speedCommand));
    hbgc_top #(.WD_CYC(300)) dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .standbyN(standbyN), .speedCommand(speedCommand),
        .directionSelect(dirSel), .pwmFreqSetPin(freqPin), .overvoltageLockout(ovl),
        .undervoltageLockout(uvl), .supervisorResetN(supN), .watchdogKick(kick),
        .speedLevel(speedLevel), .leg1LowSwitch(l1L), .leg1HighSwitch(l1H),
        .leg2LowSwitch(l2L), .leg2HighSwitch(l2H), .resetOut(resetOut),
        .resetOutEnN(resetOutEnN), .irq(irq));
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1; pwrite <= wr; paddr <= a; pwdata <= d;
        cyc(1); penable <= 1'h1;
        do cyc(1); while (pready !== 1'h1);
        r = prdata; e = pslverr;
        psel <= 1'h0; penable <= 1'h0;
        cyc(1);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_standby;
        speedIn <= 1'h1; cyc(40);
        chk(legs, 4'h0);
        apb(1'h0, ADDR_CTRL, 32'h0); chk(r, 32'h1);
        apb(1'h0, 12'h100, 32'h0); chk(r, 32'h0); chk(e, 1'h1);
    endtask
    task automatic t_dirs;
        standbyN <= 1'h1; speedIn <= 1'h0; cyc(40);
        speedIn <= 1'h1; cyc(60);
        chk(legs, 4'h6);
        dirSel <= 1'h1; cyc(60);
        chk(legs, 4'h9);
        dirSel <= 1'h0; cyc(60);
        speedIn <= 1'h0; n = 0;
        while (l2L !== 1'h0 && n < 20) begin cyc(1); n++; end
        chk(l2L, 1'h0);
        n = 0;
        while (l2H !== 1'h1 && n < 40) begin chk(legs[1:0], 2'h0); cyc(1); n++; end
        chk(n >= 25 && n <= 27, 1'h1);
    endtask
    task automatic t_brake;
        cyc(1400);
        chk(legs, 4'h5);
        chk(irq, 1'h0);
        cyc(700);
        chk(legs, 4'hA);
        apb(1'h1, ADDR_IRQ_MASK, 32'hF); cyc(3); chk(irq, 1'h1);
        apb(1'h1, ADDR_IRQ_STAT, 32'h8); cyc(3); chk(irq, 1'h0);
        dirSel <= 1'h1; cyc(60);
        chk(legs, 4'h5);
        dirSel <= 1'h0; speedIn <= 1'h1; cyc(60);
    endtask
    task automatic t_fault;
        for (int i = 0; i < 3; i++) begin
            {ovl, uvl, supN} <= (3'h4 >> i) ^ 3'h1; cyc(10);
            chk(legs, 4'h0);
            {ovl, uvl, supN} <= 3'h1; cyc(60);
            chk(legs, 4'h6);
        end
        apb(1'h0, ADDR_IRQ_STAT, 32'h0); chk(r[3:0], 4'h6);
        apb(1'h1, ADDR_IRQ_STAT, 32'h6); cyc(3); chk(irq, 1'h0);
    endtask
    task automatic t_watchdog;
        kickEn <= 1'h0; n = 0;
        while (resetOutEnN !== 1'h0 && n < 500) begin cyc(1); n++; end
        n = 0;
        while (resetOutEnN === 1'h0 && n < 300) begin cyc(1); n++; chk(legs, 4'h0); end
        chk(n, 200);
        chk(resetOut, 1'h0);
        chk(irq, 1'h1);
        cyc(30); chk(legs, 4'h0);
        kickEn <= 1'h1; cyc(100);
        chk(legs, 4'h6);
        apb(1'h1, ADDR_IRQ_STAT, 32'hF);
    endtask
    task automatic t_analog;
        freqPin <= 1'h1; speedLevel <= 8'h7A; cyc(500); n = 0;
        repeat (400) begin cyc(1); n += l2L; end
        chk(n >= 160 && n <= 200, 1'h1);
        speedLevel <= 8'hFF; cyc(500);
        chk(legs, 4'h6);
    endtask
    initial begin
        cyc(16); reset_n <= 1'h1; cyc(3);
        t_standby; t_dirs; t_brake; t_fault; t_watchdog; t_analog;
        tally_and_finish;
    end
    initial begin
        cyc(20000); failCount++;
        tally_and_finish;
    end
endmodule // hbgc_top_tb
